/* verilog/branch_logic_shift_exec.sv */
// Behaviour
// - Jump loads the 11-bit operand into program counter bits 10:0.
// - Jump fills program counter bits 14:11 from upper latch bits 6:3.
// - Jump takes two cycles, is unconditional, leaves all flags unchanged.
// - OR literal: accumulator OR 8-bit literal into accumulator, zero flag updated.
// - Increment file: file register plus one to destination, zero flag updated.
// - Destination bit 0 writes accumulator, 1 writes back the file register.
// - OR file: accumulator OR file register into destination, zero flag updated.
// - Left shift: bit 7 to carry, bits 6:0 up, zero into bit 0.
// - Right shift: zero into bit 7, bits 7:1 down, bit 0 to carry.
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module branch_logic_shift_exec (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   output logic [31:0]      hrdata
);
   localparam int AW       = 12;
   localparam int FSEL_LSB = 9;
   localparam int WORD_LSB = 2;

   exec_if ex ();

   exec_alu u_alu (
      .bus (ex.alu)
   );

   exec_pc u_pc (
      .bus (ex.pcu)
   );

   logic [exec_pkg::DATA_W-1:0]  file_mem [exec_pkg::FILE_DEPTH];

   exec_pkg::state_e              state_r;
   exec_pkg::state_e              state_nxt;
   logic [31:0]                   instr_r;
   logic [31:0]                   instr_nxt;
   logic [exec_pkg::DATA_W-1:0]   acc_r;
   logic [exec_pkg::DATA_W-1:0]   acc_nxt;
   logic                          carry_r;
   logic                          carry_nxt;
   logic                          zero_r;
   logic                          zero_nxt;
   logic [exec_pkg::LATCH_W-1:0]  latch_r;
   logic [exec_pkg::LATCH_W-1:0]  latch_nxt;
   logic [exec_pkg::PC_W-1:0]     pc_r;
   logic [exec_pkg::PC_W-1:0]     pc_nxt;

   logic                          dp_valid_r;
   logic                          dp_valid_nxt;
   logic                          dp_write_r;
   logic                          dp_write_nxt;
   logic [AW-1:0]                 dp_addr_r;
   logic [AW-1:0]                 dp_addr_nxt;
   logic                          rd_done_r;
   logic                          rd_done_nxt;
   logic [31:0]                   hrdata_r;
   logic [31:0]                   hrdata_nxt;

   logic                          busy;
   logic                          dp_file;
   logic [exec_pkg::FADDR_W-1:0]  dp_index;
   logic                          bus_write;
   logic                          file_we;
   logic [exec_pkg::FADDR_W-1:0]  file_waddr;
   logic [exec_pkg::DATA_W-1:0]   file_wdata;
   logic                          dest_file;
   logic [exec_pkg::FADDR_W-1:0]  op_faddr;
   logic                          exec_now;

   assign busy      = (state_r != exec_pkg::ST_IDLE);
   assign dp_file   = (dp_addr_r[AW-1:FSEL_LSB] == exec_pkg::FILE_REGION);
   assign dp_index  = dp_addr_r[FSEL_LSB-1:WORD_LSB];
   assign exec_now  = (state_r == exec_pkg::ST_EXEC);
   assign dest_file = instr_r[exec_pkg::INSTR_DEST_BIT];
   assign op_faddr  = instr_r[exec_pkg::INSTR_K_LSB +: exec_pkg::FADDR_W];

   // Any data phase waits while an operation runs, so software never races the datapath.
   // Reads take one extra wait cycle so that hrdata comes from a flip-flop and still
   // sees a write that completed in the cycle before.
   always_comb begin
      hreadyout = 1'b1;
      if (dp_valid_r) begin
         if (busy) begin
            hreadyout = 1'b0;
         end else if (!dp_write_r && !rd_done_r) begin
            hreadyout = 1'b0;
         end
      end
   end

   assign hresp     = exec_pkg::RESP_OKAY;
   assign hrdata    = hrdata_r;
   assign bus_write = dp_valid_r && dp_write_r && !busy;

   always_comb begin
      ex.op    = exec_pkg::op_e'(instr_r[exec_pkg::INSTR_OP_LSB +: exec_pkg::OP_W]);
      ex.acc   = acc_r;
      ex.fdata = file_mem[op_faddr];
      ex.k     = instr_r[exec_pkg::INSTR_K_LSB +: exec_pkg::JMP_W];
      ex.pc    = pc_r;
      ex.latch = latch_r;
   end

   // Bus pipeline: address phase captured only when the bus is ready.
   always_comb begin
      dp_valid_nxt = dp_valid_r;
      dp_write_nxt = dp_write_r;
      dp_addr_nxt  = dp_addr_r;
      rd_done_nxt  = rd_done_r;
      hrdata_nxt   = hrdata_r;
      if (dp_valid_r && !busy && !dp_write_r && !rd_done_r) begin
         rd_done_nxt = 1'b1;
         hrdata_nxt  = '0;
         if (dp_file) begin
            hrdata_nxt[exec_pkg::DATA_W-1:0] = file_mem[dp_index];
         end else begin
            case (dp_addr_r)
               exec_pkg::ADDR_INSTR:  hrdata_nxt = instr_r;
               exec_pkg::ADDR_ACC:    hrdata_nxt[exec_pkg::DATA_W-1:0] = acc_r;
               exec_pkg::ADDR_STATUS: begin
                  hrdata_nxt[exec_pkg::STAT_C_BIT]    = carry_r;
                  hrdata_nxt[exec_pkg::STAT_Z_BIT]    = zero_r;
                  hrdata_nxt[exec_pkg::STAT_BUSY_BIT] = busy;
               end
               exec_pkg::ADDR_LATCH:  hrdata_nxt[exec_pkg::LATCH_W-1:0] = latch_r;
               exec_pkg::ADDR_PC:     hrdata_nxt[exec_pkg::PC_W-1:0] = pc_r;
               default:               hrdata_nxt = '0;
            endcase
         end
      end
      if (hreadyout) begin
         rd_done_nxt  = 1'b0;
         dp_valid_nxt = hsel && hready && htrans[1];
         dp_write_nxt = hwrite;
         dp_addr_nxt  = haddr[AW-1:0];
      end
   end

   // Architectural state: software writes, then the running operation.
   always_comb begin
      state_nxt  = state_r;
      instr_nxt  = instr_r;
      acc_nxt    = acc_r;
      carry_nxt  = carry_r;
      zero_nxt   = zero_r;
      latch_nxt  = latch_r;
      pc_nxt     = pc_r;
      file_we    = 1'b0;
      file_waddr = dp_index;
      file_wdata = hwdata[exec_pkg::DATA_W-1:0];
      if (bus_write) begin
         if (dp_file) begin
            file_we = 1'b1;
         end else begin
            case (dp_addr_r)
               exec_pkg::ADDR_INSTR: begin
                  instr_nxt = hwdata;
                  state_nxt = exec_pkg::ST_EXEC;
               end
               exec_pkg::ADDR_ACC:    acc_nxt = hwdata[exec_pkg::DATA_W-1:0];
               exec_pkg::ADDR_STATUS: begin
                  carry_nxt = hwdata[exec_pkg::STAT_C_BIT];
                  zero_nxt  = hwdata[exec_pkg::STAT_Z_BIT];
               end
               exec_pkg::ADDR_LATCH:  latch_nxt = hwdata[exec_pkg::LATCH_W-1:0];
               exec_pkg::ADDR_PC:     pc_nxt = hwdata[exec_pkg::PC_W-1:0];
               default:               instr_nxt = instr_r;
            endcase
         end
      end
      case (state_r)
         exec_pkg::ST_EXEC: begin
            pc_nxt = ex.pc_nxt;
            if (ex.op == exec_pkg::OP_JUMP_ABSOLUTE) begin
               state_nxt = exec_pkg::ST_JUMP2;
            end else begin
               state_nxt = exec_pkg::ST_IDLE;
               if (ex.c_we) begin
                  carry_nxt = ex.c_out;
               end
               if (ex.z_we) begin
                  zero_nxt = ex.z_out;
               end
               if (ex.op == exec_pkg::OP_OR_LITERAL) begin
                  acc_nxt = ex.result;
               // Only the datapath operations write a result, so unused codes act as none.
               end else if (ex.z_we && dest_file) begin
                  file_we    = 1'b1;
                  file_waddr = op_faddr;
                  file_wdata = ex.result;
               end else if (ex.z_we) begin
                  acc_nxt = ex.result;
               end
            end
         end
         exec_pkg::ST_JUMP2: begin
            // Second jump cycle only retires; flags stay as they were.
            state_nxt = exec_pkg::ST_IDLE;
         end
         exec_pkg::ST_IDLE: begin
            state_nxt = state_nxt;
         end
         default: begin
            state_nxt = exec_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r    <= exec_pkg::ST_IDLE;
         instr_r    <= exec_pkg::INSTR_RST;
         acc_r      <= exec_pkg::ACC_RST;
         carry_r    <= 1'b0;
         zero_r     <= 1'b0;
         latch_r    <= exec_pkg::LATCH_RST;
         pc_r       <= exec_pkg::PC_RST;
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_addr_r  <= '0;
         rd_done_r  <= 1'b0;
         hrdata_r   <= '0;
      end else begin
         state_r    <= state_nxt;
         instr_r    <= instr_nxt;
         acc_r      <= acc_nxt;
         carry_r    <= carry_nxt;
         zero_r     <= zero_nxt;
         latch_r    <= latch_nxt;
         pc_r       <= pc_nxt;
         dp_valid_r <= dp_valid_nxt;
         dp_write_r <= dp_write_nxt;
         dp_addr_r  <= dp_addr_nxt;
         rd_done_r  <= rd_done_nxt;
         hrdata_r   <= hrdata_nxt;
      end
   end

   // The file array has no reset; software must initialise the words it uses.
   always_ff @(posedge hclk) begin
      if (file_we) begin
         file_mem[file_waddr] <= file_wdata;
      end
   end
endmodule
`default_nettype wire

/* pkg/exec_pkg.sv */
package exec_pkg;
   localparam int DATA_W  = 8;
   localparam int PC_W    = 15;
   localparam int JMP_W   = 11;
   localparam int FADDR_W = 7;
   localparam int LATCH_W = 7;
   localparam int OP_W    = 3;
   localparam int FILE_DEPTH = 128;

   localparam logic [11:0] ADDR_INSTR  = 12'h000;
   localparam logic [11:0] ADDR_ACC    = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_LATCH  = 12'h00C;
   localparam logic [11:0] ADDR_PC     = 12'h010;
   localparam logic [2:0]  FILE_REGION = 3'h1;

   localparam int INSTR_OP_LSB   = 0;
   localparam int INSTR_DEST_BIT = 3;
   localparam int INSTR_K_LSB    = 16;
   localparam int STAT_C_BIT     = 0;
   localparam int STAT_Z_BIT     = 1;
   localparam int STAT_BUSY_BIT  = 8;
   localparam int LATCH_HI       = 6;
   localparam int LATCH_LO       = 3;

   localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
   localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
   localparam logic [PC_W-1:0]    PC_RST    = 15'h0000;
   localparam logic [PC_W-1:0]    PC_STEP   = 15'h0001;
   localparam logic [DATA_W-1:0]  ONE_BYTE  = 8'h01;
   localparam logic [31:0]        INSTR_RST = 32'h00000000;
   localparam logic [1:0]         RESP_OKAY = 2'h0;

   typedef enum logic [OP_W-1:0] {
      OP_NONE          = 3'h0,
      OP_JUMP_ABSOLUTE = 3'h1,
      OP_OR_LITERAL    = 3'h2,
      OP_INCREMENT     = 3'h3,
      OP_OR_FILE       = 3'h4,
      OP_SHIFT_LEFT    = 3'h5,
      OP_SHIFT_RIGHT   = 3'h6
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_EXEC  = 2'h1,
      ST_JUMP2 = 2'h3
   } state_e;

   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      return (v == '0);
   endfunction
endpackage

/* pkg/exec_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface exec_if;
   exec_pkg::op_e                      op;
   logic [exec_pkg::DATA_W-1:0]        acc;
   logic [exec_pkg::DATA_W-1:0]        fdata;
   logic [exec_pkg::JMP_W-1:0]         k;
   logic [exec_pkg::DATA_W-1:0]        result;
   logic                               c_out;
   logic                               z_out;
   logic                               c_we;
   logic                               z_we;
   logic [exec_pkg::PC_W-1:0]          pc;
   logic [exec_pkg::LATCH_W-1:0]       latch;
   logic [exec_pkg::PC_W-1:0]          pc_nxt;

   modport core (output op, acc, fdata, k, pc, latch,
                 input result, c_out, z_out, c_we, z_we, pc_nxt);
   modport alu  (input op, acc, fdata, k,
                 output result, c_out, z_out, c_we, z_we);
   modport pcu  (input op, k, pc, latch, output pc_nxt);
endinterface
`default_nettype wire

/* verilog/exec_alu.sv */
`timescale 1ns/1ns
`default_nettype none
module exec_alu (
   exec_if.alu bus
);
   always_comb begin
      bus.result = bus.acc;
      bus.c_out  = 1'b0;
      bus.c_we   = 1'b0;
      bus.z_we   = 1'b0;
      case (bus.op)
         exec_pkg::OP_OR_LITERAL: begin
            bus.result = bus.acc | bus.k[exec_pkg::DATA_W-1:0];
            bus.z_we   = 1'b1;
         end
         exec_pkg::OP_INCREMENT: begin
            bus.result = bus.fdata + exec_pkg::ONE_BYTE;
            bus.z_we   = 1'b1;
         end
         exec_pkg::OP_OR_FILE: begin
            bus.result = bus.acc | bus.fdata;
            bus.z_we   = 1'b1;
         end
         exec_pkg::OP_SHIFT_LEFT: begin
            bus.result = {bus.fdata[exec_pkg::DATA_W-2:0], 1'b0};
            bus.c_out  = bus.fdata[exec_pkg::DATA_W-1];
            bus.c_we   = 1'b1;
            bus.z_we   = 1'b1;
         end
         exec_pkg::OP_SHIFT_RIGHT: begin
            bus.result = {1'b0, bus.fdata[exec_pkg::DATA_W-1:1]};
            bus.c_out  = bus.fdata[0];
            bus.c_we   = 1'b1;
            bus.z_we   = 1'b1;
         end
         default: begin
            bus.result = bus.acc;
         end
      endcase
      bus.z_out = exec_pkg::is_zero(bus.result);
   end
endmodule
`default_nettype wire

/* verilog/exec_pc.sv */
`timescale 1ns/1ns
`default_nettype none
module exec_pc (
   exec_if.pcu bus
);
   always_comb begin
      if (bus.op == exec_pkg::OP_JUMP_ABSOLUTE) begin
         // All four upper bits come from latch bits 6:3, so a jump can reach the whole space.
         bus.pc_nxt = {bus.latch[exec_pkg::LATCH_HI:exec_pkg::LATCH_LO], bus.k};
      end else begin
         bus.pc_nxt = bus.pc + exec_pkg::PC_STEP;
      end
   end
endmodule
`default_nettype wire

/* verif/exec_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module exec_sva (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic [1:0]  hresp
);
   logic        ph_r;
   logic        wr_r;
   logic [11:0] ad_r;
   logic [7:0]  acc_r;
   logic [1:0]  fl_r;
   logic        av_r;
   logic        fv_r;
   logic [6:0]  lt_r;
   logic [14:0] pc_r;
   logic        rd_done;
   logic [2:0]  op;
   logic [10:0] k;
   assign rd_done = ph_r && hready && !wr_r;
   assign op = hwdata[2:0];
   assign k = hwdata[26:16];
   // File operations are not modelled, so accumulator and flags go unchecked until rewritten.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_r <= 1'h0;
         wr_r <= 1'h0;
         ad_r <= 12'h000;
         acc_r <= 8'h00;
         fl_r <= 2'h0;
         av_r <= 1'h1;
         fv_r <= 1'h1;
         lt_r <= 7'h00;
         pc_r <= 15'h0000;
      end else begin
         if (hready) begin
            ph_r <= hsel && htrans[1];
            wr_r <= hwrite;
            ad_r <= haddr[11:0];
         end
         if (ph_r && hready && wr_r) begin
            case (ad_r)
               exec_pkg::ADDR_ACC: begin
                  acc_r <= hwdata[7:0];
                  av_r <= 1'h1;
               end
               exec_pkg::ADDR_STATUS: begin
                  fl_r <= hwdata[1:0];
                  fv_r <= 1'h1;
               end
               exec_pkg::ADDR_LATCH: lt_r <= hwdata[6:0];
               exec_pkg::ADDR_PC: pc_r <= hwdata[14:0];
               exec_pkg::ADDR_INSTR: begin
                  pc_r <= (op == 3'h1) ? {lt_r[6:3], k} : pc_r + 15'h0001;
                  if (op == 3'h2) begin
                     acc_r <= acc_r | k[7:0];
                     fl_r[1] <= (acc_r | k[7:0]) == 8'h00;
                  end else if (op >= 3'h3 && op <= 3'h6) begin
                     av_r <= 1'h0;
                     fv_r <= 1'h0;
                  end
               end
               default: ;
            endcase
         end
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_pc_low;
      (rd_done && ad_r == exec_pkg::ADDR_PC) |-> hrdata[10:0] == pc_r[10:0];
   endproperty
   a_pc_low: assert property (p_pc_low) else $error("pc low bits wrong");
   property p_pc_high;
      (rd_done && ad_r == exec_pkg::ADDR_PC) |-> hrdata[14:11] == pc_r[14:11];
   endproperty
   a_pc_high: assert property (p_pc_high) else $error("pc high bits wrong");
   property p_flags_kept;
      (rd_done && ad_r == exec_pkg::ADDR_STATUS && fv_r) |-> hrdata[0] == fl_r[0];
   endproperty
   a_flags_kept: assert property (p_flags_kept) else $error("carry changed");
   property p_acc_or;
      (rd_done && ad_r == exec_pkg::ADDR_ACC && av_r) |-> hrdata[7:0] == acc_r;
   endproperty
   a_acc_or: assert property (p_acc_or) else $error("accumulator wrong");
   property p_acc_upper;
      (rd_done && ad_r == exec_pkg::ADDR_ACC) |-> hrdata[31:8] == 24'h000000;
   endproperty
   a_acc_upper: assert property (p_acc_upper) else $error("acc upper bits set");
   property p_zero;
      (rd_done && ad_r == exec_pkg::ADDR_STATUS && fv_r) |-> hrdata[1] == fl_r[1];
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_wait_bound;
      !hreadyout [*3] |=> hreadyout;
   endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("stall too long");
   property p_read_wait;
      (hsel && hready && htrans[1] && !hwrite) |=> !hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read not staged");
   property p_resp_okay;
      hresp == 2'h0;
   endproperty
   a_resp_okay: assert property (p_resp_okay) else $error("error response seen");
endmodule
bind branch_logic_shift_exec exec_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
`default_nettype wire

/* verif/exec_master.sv */
`timescale 1ns/1ns
`default_nettype none
module exec_master (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   initial begin
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // The leading edge keeps every transfer from touching a signal twice in one step.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'h1);
      q = hrdata;
   endtask
endmodule
`default_nettype wire

/* verif/test_branch_logic_shift_exec.sv */
`timescale 1ns/1ns
`default_nettype none
module test_branch_logic_shift_exec;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic        hwrite;
   logic        hreadyout;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [1:0]  htrans;
   logic [1:0]  hresp;
   logic [2:0]  hsize;
   int          num_errors = 0;
   int          n_compared = 0;
   int          cycles = 0;
   initial hclk = 1'h0;
   always #5 hclk = ~hclk;
   exec_master u_m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   branch_logic_shift_exec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   task automatic tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_m.xfer(1'h1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      u_m.xfer(1'h0, a, 32'h0, q);
      chk(q, e);
   endtask
   function automatic logic [11:0] fa(input logic [6:0] f);
      return 12'h200 + {3'h0, f, 2'h0};
   endfunction
   task automatic run_op(input logic [2:0] op, input logic d, input logic [7:0] k,
                         input logic [7:0] av, input logic [7:0] fv, input logic [1:0] st,
                         input logic [7:0] res, input logic [1:0] se);
      wr(exec_pkg::ADDR_PC, 32'h1234);
      wr(exec_pkg::ADDR_ACC, {24'h0, av});
      wr(fa(k[6:0]), {24'h0, fv});
      wr(exec_pkg::ADDR_STATUS, {30'h0, st});
      wr(exec_pkg::ADDR_INSTR, {5'h0, 3'h0, k, 12'h0, d, op});
      rd(exec_pkg::ADDR_ACC, {24'h0, d ? av : res});
      rd(fa(k[6:0]), {24'h0, d ? res : fv});
      rd(exec_pkg::ADDR_STATUS, {30'h0, se});
      rd(exec_pkg::ADDR_PC, 32'h1235);
   endtask
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      hresetn = 1'h0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      for (int a = 0; a <= 16; a += 4)
         rd(a[11:0], 32'h0);
      wr(12'h100, 32'hFFFFFFFF);
      rd(12'h100, 32'h0);
      // Latch bits 6:3 and 4:3 differ here, so the wrong slice shows up.
      wr(exec_pkg::ADDR_LATCH, 32'h5A);
      wr(exec_pkg::ADDR_STATUS, 32'h3);
      wr(exec_pkg::ADDR_INSTR, 32'h07FF0001);
      rd(exec_pkg::ADDR_PC, 32'h5FFF);
      rd(exec_pkg::ADDR_STATUS, 32'h3);
      wr(exec_pkg::ADDR_INSTR, 32'h00000001);
      rd(exec_pkg::ADDR_PC, 32'h5800);
      wr(exec_pkg::ADDR_PC, 32'h7FFF);
      wr(exec_pkg::ADDR_INSTR, 32'h0);
      rd(exec_pkg::ADDR_PC, 32'h0);
      run_op(3'h2, 1'h0, 8'h00, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2);
      run_op(3'h2, 1'h0, 8'h0A, 8'h50, 8'h00, 2'h2, 8'h5A, 2'h0);
      run_op(3'h2, 1'h0, 8'hFF, 8'h00, 8'h00, 2'h1, 8'hFF, 2'h1);
      run_op(3'h3, 1'h1, 8'h7F, 8'h11, 8'hFF, 2'h1, 8'h00, 2'h3);
      run_op(3'h3, 1'h0, 8'h00, 8'h11, 8'h7F, 2'h2, 8'h80, 2'h0);
      run_op(3'h4, 1'h1, 8'h05, 8'h0F, 8'hF0, 2'h2, 8'hFF, 2'h0);
      run_op(3'h4, 1'h0, 8'h06, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2);
      run_op(3'h5, 1'h1, 8'h01, 8'h00, 8'h81, 2'h0, 8'h02, 2'h1);
      run_op(3'h5, 1'h0, 8'h02, 8'h33, 8'h80, 2'h0, 8'h00, 2'h3);
      run_op(3'h6, 1'h1, 8'h03, 8'h00, 8'h01, 2'h0, 8'h00, 2'h3);
      run_op(3'h6, 1'h0, 8'h04, 8'h00, 8'hFE, 2'h1, 8'h7F, 2'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
